/* File: rtl/ucfg_pkg.sv */
package ucfg_pkg;

  // readback bit layout of the low control fields; bits 7, 2 and 1 read as zero
  localparam int CFG_W             = 9;
  localparam int POS_LAST_CLK      = 8;
  localparam int POS_BRK_IRQ_EN    = 6;
  localparam int POS_BRK_LEN       = 5;
  localparam int POS_ADDR_WIDTH    = 4;
  localparam int POS_IGNORE_SEL    = 3;
  localparam int POS_SLAVE_EN      = 0;

  // word length encodings on WORD_LEN_I
  localparam logic [1:0] WLEN_8    = 2'h0;
  localparam logic [1:0] WLEN_9    = 2'h1;
  localparam logic [1:0] WLEN_7    = 2'h2;

  localparam logic [3:0] BITS_7    = 4'h7;
  localparam logic [3:0] BITS_8    = 4'h8;
  localparam logic [3:0] BITS_9    = 4'h9;

  // break detector thresholds in bit times
  localparam logic [3:0] BRK_THR_SHORT = 4'hA;
  localparam logic [3:0] BRK_THR_LONG  = 4'hB;

  // address compare masks
  localparam logic [7:0] AMASK_4   = 8'h0F;
  localparam logic [7:0] AMASK_6   = 8'h3F;
  localparam logic [7:0] AMASK_7   = 8'h7F;
  localparam logic [7:0] AMASK_8   = 8'hFF;

  localparam logic [15:0] HALF_DIV_DEFAULT = 16'h0008;

  typedef enum logic {UCFG_IDLE, UCFG_SHIFT} ucfg_tx_e;

  function automatic logic [3:0] ucfg_word_bits(input logic [1:0] len);
    if (len == WLEN_7)
      return BITS_7;
    else if (len == WLEN_9)
      return BITS_9;
    else
      return BITS_8;
  endfunction

  function automatic logic [7:0] ucfg_addr_mask(input logic [1:0] len, input logic addr7);
    if (len == WLEN_7)
      return AMASK_6;
    else if (len == WLEN_9)
      return AMASK_8;
    else if (addr7)
      return AMASK_7;
    else
      return AMASK_4;
  endfunction

endpackage

/* File: rtl/ucfg_brk_if.sv */
`timescale 1ns/1ps
interface ucfg_brk_if;
  logic tick;
  logic rx_level;
  logic long_break;
  logic brk_pulse;

  modport owner    (output tick, output rx_level, output long_break, input brk_pulse);
  modport detector (input tick, input rx_level, input long_break, output brk_pulse);
endinterface

/* File: rtl/ucfg_brk_det.sv */
`timescale 1ns/1ps
module ucfg_brk_det
  import ucfg_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       srst_i,
  ucfg_brk_if.detector    det
);

  typedef struct packed {
    logic [3:0] cnt;
    logic       fired;
    logic       pulse;
  } ucfg_det_s;

  ucfg_det_s  st;
  ucfg_det_s  next_st;
  logic [3:0] thr;

  assign thr           = det.long_break ? BRK_THR_LONG : BRK_THR_SHORT;
  assign det.brk_pulse = st.pulse;

  always_comb
  begin
    next_st       = st;
    next_st.pulse = 1'b0;
    if (det.tick)
    begin
      if (det.rx_level)
      begin
        next_st.cnt   = 4'h0;
        next_st.fired = 1'b0;
      end
      else if (!st.fired)
      begin
        next_st.cnt = st.cnt + 4'h1;
        // one pulse per low stretch, however long it lasts
        if (st.cnt + 4'h1 == thr)
        begin
          next_st.pulse = 1'b1;
          next_st.fired = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      st <= '0;
    else
      st <= next_st;
  end

  brk_len_a: assert property (@(posedge clk_i) disable iff (srst_i)
    st.pulse |-> st.cnt == $past(thr))
    else $error("break pulse at wrong low count");

endmodule // ucfg_brk_det

/* File: rtl/ucfg_top.sv */
`timescale 1ns/1ps
// Contract
// - last bit clock pulse follows its field
// - last bit is 7th, 8th or 9th
// - locked fields written only while unit disabled
// - break flag raises interrupt when enabled
// - break length selects 10 or 11 bits
// - address width selects 4 or 7 bits
// - 7/9-bit words match 6/8-bit address
// - ignore-select forces an enabled slave always selected
// - otherwise selection follows select pin
// - slave enable turns slave operation on
// - unsupported features hold their bits zero
// - clock idles at programmed polarity level
module ucfg_top
  import ucfg_pkg::*;
#(
  parameter bit          SYNC_SUPPORT      = 1'b1,
  parameter bit          LIN_SUPPORT       = 1'b1,
  parameter bit          SPI_SLAVE_SUPPORT = 1'b1,
  parameter logic [15:0] HALF_DIV          = HALF_DIV_DEFAULT
)
(
  input  wire logic              CLK_I,
  input  wire logic              SRST_I,
  input  wire logic              UNIT_ENABLE_I,
  input  wire logic              CFG_WRITE_I,
  input  wire logic              CFG_LAST_CLOCK_PULSE_OUT_I,
  input  wire logic              CFG_BREAK_IRQ_ENABLE_I,
  input  wire logic              CFG_BREAK_DETECT_LENGTH_I,
  input  wire logic              CFG_ADDRESS_WIDTH_SELECT_I,
  input  wire logic              CFG_IGNORE_SELECT_PIN_I,
  input  wire logic              CFG_SYNC_SLAVE_ENABLE_I,
  input  wire logic              CFG_CLOCK_IDLE_LEVEL_I,
  input  wire logic [1:0]        WORD_LEN_I,
  input  wire logic              TX_START_I,
  input  wire logic [8:0]        TX_DATA_I,
  input  wire logic              RXD_I,
  input  wire logic              SLAVE_SELECT_N_I,
  input  wire logic              BREAK_CLEAR_I,
  input  wire logic              OTHER_IRQ_I,
  input  wire logic [7:0]        NODE_ADDR_I,
  input  wire logic [8:0]        RX_WORD_I,
  input  wire logic              RX_WORD_VALID_I,
  output logic [CFG_W-1:0]       CFG_READBACK_O,
  output logic                   TX_BUSY_O,
  output logic                   TXD_O,
  output logic                   SCLK_O,
  output logic                   BREAK_DETECTED_FLAG_O,
  output logic                   IRQ_O,
  output logic                   ADDR_MATCH_O,
  output logic                   SLAVE_SELECTED_O,
  output logic                   SYNC_SLAVE_ACTIVE_O
);

  typedef struct packed {
    logic last_clock_pulse_out;
    logic break_irq_enable;
    logic break_detect_length;
    logic address_width_select;
    logic ignore_select_pin;
    logic sync_slave_enable;
    logic clock_idle_level;
  } ucfg_cfg_s;

  typedef struct packed {
    ucfg_cfg_s  cfg;
    ucfg_tx_e   tx_state;
    logic [8:0] shreg;
    logic [3:0] bits_left;
    logic       half;
    logic [15:0] div;
    logic       rx_phase;
    logic       sclk;
    logic       txd;
    logic       rx_s1;
    logic       rx_s2;
    logic       ss_s1;
    logic       ss_s2;
    logic       brk_flag;
    logic       match;
  } ucfg_state_s;

  ucfg_state_s st;
  ucfg_state_s next_st;
  logic        half_tick;
  logic        last_bit;
  logic        start_ok;
  logic [7:0]  amask;

  ucfg_brk_if brk ();

  ucfg_brk_det u_brk_det (
    .clk_i  (CLK_I),
    .srst_i (SRST_I),
    .det    (brk.detector)
  );

  assign half_tick      = (st.div == HALF_DIV - 16'h0001);
  assign last_bit       = (st.bits_left == 4'h1);
  assign start_ok       = TX_START_I && UNIT_ENABLE_I && SYNC_SUPPORT
                          && !st.cfg.sync_slave_enable && (st.tx_state == UCFG_IDLE);
  assign amask          = ucfg_addr_mask(WORD_LEN_I, st.cfg.address_width_select);

  // rx sampled once per bit time, on every second half tick
  assign brk.tick       = half_tick && st.rx_phase;
  assign brk.rx_level   = st.rx_s2;
  assign brk.long_break = st.cfg.break_detect_length;

  always_comb
  begin
    next_st       = st;
    next_st.rx_s1 = RXD_I;
    next_st.rx_s2 = st.rx_s1;
    next_st.ss_s1 = SLAVE_SELECT_N_I;
    next_st.ss_s2 = st.ss_s1;

    // configuration; the locked fields need the unit disabled
    if (CFG_WRITE_I)
    begin
      next_st.cfg.break_irq_enable  = CFG_BREAK_IRQ_ENABLE_I && LIN_SUPPORT;
      next_st.cfg.ignore_select_pin = CFG_IGNORE_SELECT_PIN_I && SPI_SLAVE_SUPPORT;
      next_st.cfg.sync_slave_enable = CFG_SYNC_SLAVE_ENABLE_I && SPI_SLAVE_SUPPORT;
      if (!UNIT_ENABLE_I)
      begin
        next_st.cfg.last_clock_pulse_out = CFG_LAST_CLOCK_PULSE_OUT_I && SYNC_SUPPORT;
        next_st.cfg.break_detect_length  = CFG_BREAK_DETECT_LENGTH_I && LIN_SUPPORT;
        next_st.cfg.address_width_select = CFG_ADDRESS_WIDTH_SELECT_I;
        next_st.cfg.clock_idle_level     = CFG_CLOCK_IDLE_LEVEL_I && SYNC_SUPPORT;
      end
    end

    // free-running divider, realigned on each start so bit timing is exact
    if (half_tick || start_ok)
      next_st.div = 16'h0000;
    else
      next_st.div = st.div + 16'h0001;
    if (half_tick)
      next_st.rx_phase = !st.rx_phase;

    case (st.tx_state)
      UCFG_IDLE:
      begin
        next_st.sclk = st.cfg.clock_idle_level;
        next_st.txd  = 1'b1;
        if (start_ok)
        begin
          next_st.tx_state  = UCFG_SHIFT;
          next_st.shreg     = TX_DATA_I >> 1;
          next_st.txd       = TX_DATA_I[0];
          next_st.bits_left = ucfg_word_bits(WORD_LEN_I);
          next_st.half      = 1'b0;
        end
      end
      UCFG_SHIFT:
      begin
        if (half_tick)
        begin
          if (!st.half)
          begin
            next_st.half = 1'b1;
            // the last bit may be sent with its clock pulse withheld
            if (last_bit && !st.cfg.last_clock_pulse_out)
              next_st.sclk = st.cfg.clock_idle_level;
            else
              next_st.sclk = !st.cfg.clock_idle_level;
          end
          else
          begin
            next_st.half = 1'b0;
            next_st.sclk = st.cfg.clock_idle_level;
            if (last_bit)
            begin
              next_st.tx_state = UCFG_IDLE;
              next_st.txd      = 1'b1;
            end
            else
            begin
              next_st.bits_left = st.bits_left - 4'h1;
              next_st.txd       = st.shreg[0];
              next_st.shreg     = st.shreg >> 1;
            end
          end
        end
      end
      default:
        next_st.tx_state = UCFG_IDLE;
    endcase

    // new break beats a clear in the same cycle
    if (brk.brk_pulse && LIN_SUPPORT)
      next_st.brk_flag = 1'b1;
    else if (BREAK_CLEAR_I)
      next_st.brk_flag = 1'b0;

    if (RX_WORD_VALID_I)
      next_st.match = ((RX_WORD_I[7:0] ^ NODE_ADDR_I) & amask) == 8'h00;
  end

  always_ff @(posedge CLK_I)
  begin
    if (SRST_I)
    begin
      st       <= '0;
      st.sclk  <= 1'b0;
      st.txd   <= 1'b1;
      st.rx_s1 <= 1'b1;
      st.rx_s2 <= 1'b1;
      st.ss_s1 <= 1'b1;
      st.ss_s2 <= 1'b1;
    end
    else
      st <= next_st;
  end

  always_comb
  begin
    CFG_READBACK_O                 = '0;
    CFG_READBACK_O[POS_LAST_CLK]   = st.cfg.last_clock_pulse_out;
    CFG_READBACK_O[POS_BRK_IRQ_EN] = st.cfg.break_irq_enable;
    CFG_READBACK_O[POS_BRK_LEN]    = st.cfg.break_detect_length;
    CFG_READBACK_O[POS_ADDR_WIDTH] = st.cfg.address_width_select;
    CFG_READBACK_O[POS_IGNORE_SEL] = st.cfg.ignore_select_pin;
    CFG_READBACK_O[POS_SLAVE_EN]   = st.cfg.sync_slave_enable;
  end

  assign TX_BUSY_O             = (st.tx_state == UCFG_SHIFT);
  assign TXD_O                 = st.txd;
  assign SCLK_O                = st.sclk;
  assign BREAK_DETECTED_FLAG_O = st.brk_flag;
  assign IRQ_O                 = (st.brk_flag && st.cfg.break_irq_enable)
                                 || OTHER_IRQ_I;
  assign ADDR_MATCH_O          = st.match;
  assign SYNC_SLAVE_ACTIVE_O   = st.cfg.sync_slave_enable;
  assign SLAVE_SELECTED_O      = st.cfg.sync_slave_enable
                                 && (st.cfg.ignore_select_pin || !st.ss_s2);

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (SRST_I);

  sequence last_half_s;
    st.tx_state == UCFG_SHIFT && half_tick && !st.half && last_bit;
  endsequence

  cfg_lock_a: assert property (
    UNIT_ENABLE_I |=> $stable({st.cfg.last_clock_pulse_out, st.cfg.break_detect_length,
                               st.cfg.address_width_select}))
    else $error("locked field changed while unit enabled");

  last_pulse_off_a: assert property (
    last_half_s and !st.cfg.last_clock_pulse_out |=> SCLK_O == $past(st.cfg.clock_idle_level))
    else $error("last bit clock pulse not suppressed");

  last_pulse_on_a: assert property (
    last_half_s and st.cfg.last_clock_pulse_out |=> SCLK_O != $past(st.cfg.clock_idle_level))
    else $error("last bit clock pulse missing");

  word_bits_a: assert property (
    start_ok && WORD_LEN_I == WLEN_7 |=> st.bits_left == BITS_7)
    else $error("seven bit word not loaded");

  idle_level_a: assert property (
    st.tx_state == UCFG_IDLE && $past(st.tx_state) == UCFG_IDLE
    && $stable(st.cfg.clock_idle_level) |-> SCLK_O == st.cfg.clock_idle_level)
    else $error("clock not at idle level");

  brk_irq_a: assert property (
    st.brk_flag && st.cfg.break_irq_enable |-> IRQ_O)
    else $error("break interrupt not raised");

  brk_set_a: assert property (
    brk.brk_pulse && LIN_SUPPORT |=> BREAK_DETECTED_FLAG_O ##0 (IRQ_O || !st.cfg.break_irq_enable))
    else $error("break event lost");

  addr_four_a: assert property (
    RX_WORD_VALID_I && WORD_LEN_I == WLEN_8 && !st.cfg.address_width_select
    && RX_WORD_I[3:0] == NODE_ADDR_I[3:0] |=> ADDR_MATCH_O)
    else $error("four bit address not matched");

  addr_six_a: assert property (
    RX_WORD_VALID_I && WORD_LEN_I == WLEN_7 && RX_WORD_I[6] != NODE_ADDR_I[6]
    && RX_WORD_I[5:0] == NODE_ADDR_I[5:0] |=> ADDR_MATCH_O)
    else $error("six bit address not matched");

  select_ign_a: assert property (
    st.cfg.sync_slave_enable && st.cfg.ignore_select_pin |-> SLAVE_SELECTED_O)
    else $error("slave not forced selected");

  select_pin_a: assert property (
    st.cfg.sync_slave_enable && !st.cfg.ignore_select_pin && st.ss_s2 |-> !SLAVE_SELECTED_O)
    else $error("slave selected with pin high");

  slave_en_a: assert property (
    CFG_WRITE_I && SPI_SLAVE_SUPPORT |=> SYNC_SLAVE_ACTIVE_O == $past(CFG_SYNC_SLAVE_ENABLE_I))
    else $error("slave enable not taken");

  reserved_a: assert property (
    !LIN_SUPPORT |-> !CFG_READBACK_O[POS_BRK_IRQ_EN] && !CFG_READBACK_O[POS_BRK_LEN])
    else $error("unsupported field not zero");

endmodule // ucfg_top

/* File: sim/ucfg_far_end.sv */
`timescale 1ns/1ps
module ucfg_far_end
#(
  parameter int BIT_CYC = 4
)
(
  input  wire logic clk_i,
  input  wire logic txd_i,
  input  wire logic sclk_i,
  input  wire logic idle_level_i,
  output logic      rxd_o,
  output logic      select_n_o
);
  logic [8:0] cap;
  int         pulses;
  logic       armed;

  initial
  begin
    rxd_o      = 1'b1;
    select_n_o = 1'b1;
    armed      = 1'b0;
    pulses     = 0;
    cap        = '0;
  end

  // data taken on the leading edge of each pulse away from idle
  always @(sclk_i)
  begin
    if (armed && sclk_i !== idle_level_i && pulses < 9)
    begin
      cap[pulses] = txd_i;
      pulses      = pulses + 1;
    end
  end

  task automatic arm(input logic on);
    armed = on;
    if (on)
    begin
      pulses = 0;
      cap    = '0;
    end
  endtask

  // line pulled up again after the low run
  task automatic send_low(input int nbits);
    rxd_o = 1'b0;
    repeat (nbits * BIT_CYC) @(negedge clk_i);
    rxd_o = 1'b1;
    repeat (3 * BIT_CYC) @(negedge clk_i);
  endtask
endmodule // ucfg_far_end

/* File: sim/tb_ucfg_top.sv */
`timescale 1ns/1ps
module tb_ucfg_top;
  import ucfg_pkg::*;
  logic CLK_I = 0, SRST_I = 1, UNIT_ENABLE_I = 0, CFG_WRITE_I = 0, CFG_LAST_CLOCK_PULSE_OUT_I = 0;
  logic CFG_BREAK_IRQ_ENABLE_I = 0, CFG_BREAK_DETECT_LENGTH_I = 0, CFG_ADDRESS_WIDTH_SELECT_I = 0;
  logic CFG_IGNORE_SELECT_PIN_I = 0, CFG_SYNC_SLAVE_ENABLE_I = 0, CFG_CLOCK_IDLE_LEVEL_I = 0;
  logic [1:0] WORD_LEN_I = 0;
  logic TX_START_I = 0, BREAK_CLEAR_I = 0, OTHER_IRQ_I = 0, RX_WORD_VALID_I = 0;
  logic [8:0] TX_DATA_I = 0, RX_WORD_I = 0, CFG_READBACK_O, rb_bare, data, mask;
  logic [7:0] NODE_ADDR_I = 8'hA5;
  logic RXD_I, SLAVE_SELECT_N_I, TX_BUSY_O, TXD_O, SCLK_O, BREAK_DETECTED_FLAG_O, IRQ_O;
  logic ADDR_MATCH_O, SLAVE_SELECTED_O, SYNC_SLAVE_ACTIVE_O;
  logic bare_busy, bare_txd, bare_sclk, bare_flag, bare_irq, bare_match, bare_sel, bare_slv;
  int fails = 0, samples_checked = 0, k, np;
  logic [12:0] atab [7] = '{{WLEN_8, 1'b0, 9'h035, 1'b1}, {WLEN_8, 1'b1, 9'h035, 1'b0},
    {WLEN_8, 1'b1, 9'h125, 1'b1}, {WLEN_7, 1'b0, 9'h0E5, 1'b1}, {WLEN_7, 1'b1, 9'h035, 1'b0},
    {WLEN_9, 1'b0, 9'h025, 1'b0}, {WLEN_9, 1'b0, 9'h0A5, 1'b1}};
  logic [1:0] lens [3] = '{WLEN_7, WLEN_8, WLEN_9};
  int nbits [3] = '{7, 8, 9};

  ucfg_top #(.HALF_DIV(16'h0002)) uut (.CLK_I, .SRST_I, .UNIT_ENABLE_I, .CFG_WRITE_I,
    .CFG_LAST_CLOCK_PULSE_OUT_I, .CFG_BREAK_IRQ_ENABLE_I, .CFG_BREAK_DETECT_LENGTH_I,
    .CFG_ADDRESS_WIDTH_SELECT_I, .CFG_IGNORE_SELECT_PIN_I, .CFG_SYNC_SLAVE_ENABLE_I,
    .CFG_CLOCK_IDLE_LEVEL_I, .WORD_LEN_I, .TX_START_I, .TX_DATA_I, .RXD_I, .SLAVE_SELECT_N_I,
    .BREAK_CLEAR_I, .OTHER_IRQ_I, .NODE_ADDR_I, .RX_WORD_I, .RX_WORD_VALID_I, .CFG_READBACK_O,
    .TX_BUSY_O, .TXD_O, .SCLK_O, .BREAK_DETECTED_FLAG_O, .IRQ_O, .ADDR_MATCH_O,
    .SLAVE_SELECTED_O, .SYNC_SLAVE_ACTIVE_O);

  // stripped-down build: no sync, LIN or slave support
  ucfg_top #(.SYNC_SUPPORT(1'b0), .LIN_SUPPORT(1'b0), .SPI_SLAVE_SUPPORT(1'b0),
    .HALF_DIV(16'h0002)) uut_bare (.CLK_I, .SRST_I, .UNIT_ENABLE_I, .CFG_WRITE_I,
    .CFG_LAST_CLOCK_PULSE_OUT_I, .CFG_BREAK_IRQ_ENABLE_I, .CFG_BREAK_DETECT_LENGTH_I,
    .CFG_ADDRESS_WIDTH_SELECT_I, .CFG_IGNORE_SELECT_PIN_I, .CFG_SYNC_SLAVE_ENABLE_I,
    .CFG_CLOCK_IDLE_LEVEL_I, .WORD_LEN_I, .TX_START_I, .TX_DATA_I, .RXD_I, .SLAVE_SELECT_N_I,
    .BREAK_CLEAR_I, .OTHER_IRQ_I, .NODE_ADDR_I, .RX_WORD_I, .RX_WORD_VALID_I,
    .CFG_READBACK_O(rb_bare), .TX_BUSY_O(bare_busy), .TXD_O(bare_txd), .SCLK_O(bare_sclk),
    .BREAK_DETECTED_FLAG_O(bare_flag), .IRQ_O(bare_irq), .ADDR_MATCH_O(bare_match),
    .SLAVE_SELECTED_O(bare_sel), .SYNC_SLAVE_ACTIVE_O(bare_slv));

  ucfg_far_end #(.BIT_CYC(4)) far (.clk_i(CLK_I), .txd_i(TXD_O), .sclk_i(SCLK_O),
    .idle_level_i(CFG_CLOCK_IDLE_LEVEL_I), .rxd_o(RXD_I), .select_n_o(SLAVE_SELECT_N_I));

  initial
  begin
    forever #4 CLK_I = ~CLK_I;
  end

  task automatic summarize();
    if (fails == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // f = {last, brk irq en, brk len, addr width, ignore sel, slave en, idle}
  task automatic wr(input logic ue, input logic [6:0] f);
    @(negedge CLK_I);
    UNIT_ENABLE_I = ue;
    {CFG_LAST_CLOCK_PULSE_OUT_I, CFG_BREAK_IRQ_ENABLE_I, CFG_BREAK_DETECT_LENGTH_I,
      CFG_ADDRESS_WIDTH_SELECT_I, CFG_IGNORE_SELECT_PIN_I, CFG_SYNC_SLAVE_ENABLE_I,
      CFG_CLOCK_IDLE_LEVEL_I} = f;
    CFG_WRITE_I = 1'b1;
    @(negedge CLK_I);
    CFG_WRITE_I = 1'b0;
  endtask

  task automatic nap(input int n);
    repeat (n) @(negedge CLK_I);
  endtask

  initial
  begin
    repeat (20000) @(posedge CLK_I);
    fails++;
    summarize();
  end

  initial
  begin
    nap(12);
    SRST_I = 0;
    nap(1);
    chk(CFG_READBACK_O, 0);
    chk({TXD_O, SCLK_O, IRQ_O, BREAK_DETECTED_FLAG_O}, 4'h8);
    wr(0, 7'h7F); // reserved positions have no inputs, always zero
    chk(CFG_READBACK_O, 9'h179);
    chk(rb_bare, 9'h010);
    // clock pin follows the idle field one cycle after the write
    nap(1);
    chk({SYNC_SLAVE_ACTIVE_O, SCLK_O}, 2'h3);
    chk({bare_sclk, bare_slv, bare_sel, bare_txd}, 4'h1);
    wr(1, 7'h00);
    chk(CFG_READBACK_O, 9'h130);
    chk({SYNC_SLAVE_ACTIVE_O, SCLK_O}, 2'h1);
    wr(0, 7'h02);
    nap(4);
    chk(SLAVE_SELECTED_O, 0);
    far.select_n_o = 1'b0;
    nap(4);
    chk(SLAVE_SELECTED_O, 1);
    far.select_n_o = 1'b1;
    wr(0, 7'h06);
    nap(4);
    chk(SLAVE_SELECTED_O, 1);
    wr(0, 7'h04);
    chk({SLAVE_SELECTED_O, SYNC_SLAVE_ACTIVE_O}, 0);
    // clock fields only change with the unit disabled
    for (int i = 0; i < 6; i++)
    begin
      wr(0, {i[2] | i[1] & i[0], 5'h00, i[0]});
      nap(2);
      chk(SCLK_O, i[0]);
      np = nbits[i % 3] - 1 + (i >= 3);
      data = 9'h1B5 ^ 9'(i * 37);
      mask = 9'((1 << np) - 1);
      far.arm(1);
      UNIT_ENABLE_I = 1;
      WORD_LEN_I = lens[i % 3];
      TX_DATA_I = data;
      TX_START_I = 1;
      nap(1);
      TX_START_I = 0;
      chk({bare_busy, bare_txd}, 2'h1);
      k = 0;
      while (TX_BUSY_O !== 1'b0 && k < 200)
      begin
        nap(1);
        k++;
      end
      far.arm(0);
      chk(16'(far.pulses), 16'(np));
      chk(far.cap & mask, data & mask);
      chk({TXD_O, SCLK_O}, {1'b1, i[0]});
      UNIT_ENABLE_I = 0;
    end
    wr(0, 7'h20);
    BREAK_CLEAR_I = 1;
    nap(1);
    BREAK_CLEAR_I = 0;
    far.send_low(9);
    nap(1);
    chk(BREAK_DETECTED_FLAG_O, 0);
    far.send_low(11);
    nap(1);
    chk({BREAK_DETECTED_FLAG_O, IRQ_O}, 2'h3);
    chk({bare_flag, bare_irq}, 2'h0);
    wr(0, 7'h00);
    chk(IRQ_O, 0);
    OTHER_IRQ_I = 1;
    nap(1);
    chk(IRQ_O, 1);
    OTHER_IRQ_I = 0;
    BREAK_CLEAR_I = 1;
    wr(0, 7'h30);
    BREAK_CLEAR_I = 0;
    chk(BREAK_DETECTED_FLAG_O, 0);
    far.send_low(10);
    nap(1);
    chk(BREAK_DETECTED_FLAG_O, 0);
    far.send_low(12);
    nap(1);
    chk(BREAK_DETECTED_FLAG_O, 1);
    foreach (atab[j])
    begin
      wr(0, {3'h0, atab[j][10], 3'h0});
      {WORD_LEN_I, RX_WORD_I} = {atab[j][12:11], atab[j][9:1]};
      RX_WORD_VALID_I = 1;
      nap(1);
      RX_WORD_VALID_I = 0;
      nap(1);
      chk(ADDR_MATCH_O, atab[j][0]);
      chk(bare_match, atab[j][0]);
    end
    summarize();
  end
endmodule // tb_ucfg_top
